// File: slmc_map.vh
// Constants for the loop mask control block: register offsets, fields, codes.
// Assumes inclusion by bare name from the design file.
`ifndef SLMC_MAP_VH
`define SLMC_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SLMC_REG_CTRL        8'h00
`define SLMC_REG_STATUS      8'h04
`define SLMC_REG_LOOP_MASK   8'h08
`define SLMC_REG_CONT_MASK   8'h0c
`define SLMC_REG_FLAG01      8'h10
`define SLMC_REG_FLAG23      8'h14

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SLMC_CTRL_ENABLE     0
`define SLMC_CTRL_STK_CLR    1
`define SLMC_ST_OVF          8
`define SLMC_ST_UNF          9
`define SLMC_CTRL_RST        32'h0000_0001
`define SLMC_MASK_RST        16'h0000
`define SLMC_IP_ALIGN_BITS   3

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define SLMC_OP_NOP          4'h0
`define SLMC_OP_SAVE_LOOP    4'h1
`define SLMC_OP_SAVE_CONT    4'h2
`define SLMC_OP_CONT_RELOAD  4'h3
`define SLMC_OP_LOOP_TAIL    4'h4
`define SLMC_OP_BREAK        4'h5
`define SLMC_OP_SKIP         4'h6
`define SLMC_OP_FLAG_AND     4'h7
`define SLMC_OP_FLAG_OR      4'h8
`define SLMC_OP_FLAG_XOR     4'h9
`define SLMC_OP_ALL4_BRANCH  4'ha
`define SLMC_OP_JUMP_INDEX   4'hb

`endif

// File: slmc_loop_mask_ctrl.v
// Loop, continue and flag mask control for a 16-channel SIMD execution unit.
// Assumes a classic Wishbone master and an in-order instruction stream.
// Operation
// - Keep 16-bit loop mask, one bit per channel
// - Save instruction pushes old mask, then updates
// - Tail result is alive AND continue AND flag AND loop mask
// - Tail writes loop mask, loops while nonzero
// - Terminated channel stays off until loop ends
// - Fall-through pops continue then loop mask
// - Break clears enabled bits, branches when empty
// - Continue mask skips channels for one pass
// - All-four predicate ANDs four flag registers
// - Indexed jump adds register offset to IP
// - Branch targets kept 8-byte aligned
// - Flag registers combine by logic operations
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`include "slmc_map.vh"
`timescale 1ns/1ps
`default_nettype none

module slmc_loop_mask_ctrl #(
   parameter CHANNELS    = 16,
   parameter STACK_DEPTH = 16,
   parameter PTR_W       = 5
) (
   // Clock and reset
   input  wire                clk_i,
   input  wire                rstn_i,
   // Wishbone slave
   input  wire                wb_cyc_i,
   input  wire                wb_stb_i,
   input  wire                wb_we_i,
   input  wire [7:0]          wb_adr_i,
   input  wire [3:0]          wb_sel_i,
   input  wire [31:0]         wb_dat_i,
   output reg  [31:0]         wb_dat_o,
   output reg                 wb_ack_o,
   // Instruction stream
   input  wire                instr_valid_i,
   output wire                instr_ready_o,
   input  wire [3:0]          instr_op_i,
   input  wire [1:0]          instr_flag_sel_i,
   input  wire [1:0]          instr_flag_src_i,
   input  wire [31:0]         instr_operand_i,
   input  wire [31:0]         instr_ip_i,
   input  wire [CHANNELS-1:0] exec_mask_i,
   input  wire [CHANNELS-1:0] alive_mask_i,
   // Results
   output reg                 done_o,
   output reg                 branch_taken_o,
   output reg  [31:0]         branch_ip_o,
   output reg  [15:0]         cond_pop_count_o,
   output reg  [CHANNELS-1:0] pred_mask_o,
   output wire [CHANNELS-1:0] loop_channel_mask_o,
   output wire [CHANNELS-1:0] skip_channel_mask_o
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   // One loop mask bit per channel
   reg  [CHANNELS-1:0] loop_q;
   reg  [CHANNELS-1:0] cont_q;
   reg  [CHANNELS-1:0] flag_q [0:3];
   reg  [CHANNELS-1:0] stack_q [0:STACK_DEPTH-1];
   reg  [PTR_W-1:0]    sp_q;
   reg                 ovf_q;
   reg                 unf_q;
   reg  [31:0]         ctrl_q;
   integer             i;

   wire enable = ctrl_q[`SLMC_CTRL_ENABLE];
   assign instr_ready_o       = enable;
   assign loop_channel_mask_o = loop_q;
   assign skip_channel_mask_o = cont_q;

   wire fire = instr_valid_i & enable;
   wire [CHANNELS-1:0] flag_sel = flag_q[instr_flag_sel_i];

   // ----------------------------------------
   // Per-instruction mask evaluation
   // ----------------------------------------
   // Channel keep condition
   wire [CHANNELS-1:0] tail_res = alive_mask_i & cont_q & flag_sel & loop_q;
   wire [CHANNELS-1:0] brk_loop = loop_q & ~exec_mask_i;
   wire [CHANNELS-1:0] brk_cont = cont_q & ~exec_mask_i;
   wire [CHANNELS-1:0] all4 = flag_q[0] & flag_q[1] & flag_q[2] & flag_q[3];

   wire [31:0] rel_ip = instr_ip_i + {16'h0000, instr_operand_i[15:0]};
   wire [31:0] rel_al = {rel_ip[31:`SLMC_IP_ALIGN_BITS], 3'h0};
   wire [31:0] idx_ip = instr_ip_i + instr_operand_i;
   wire [31:0] idx_al = {idx_ip[31:`SLMC_IP_ALIGN_BITS], 3'h0};

   wire        push_req  = fire & ((instr_op_i == `SLMC_OP_SAVE_LOOP) |
                                   (instr_op_i == `SLMC_OP_SAVE_CONT));
   wire        tail_pop  = fire & (instr_op_i == `SLMC_OP_LOOP_TAIL) & ~(|tail_res);
   wire        stk_full  = (sp_q == STACK_DEPTH[PTR_W-1:0]);
   wire        stk_short = (sp_q < 5'h02);
   wire [PTR_W-1:0] sp_m1 = sp_q - 5'h01;
   wire [PTR_W-1:0] sp_m2 = sp_q - 5'h02;

   // Byte-lane merge for register writes
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  sel;
      integer b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (sel[b])
               merge[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
   endfunction

   // ----------------------------------------
   // Wishbone decode
   // ----------------------------------------
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // Writes land on the edge at which the master samples ack high
   wire wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
   wire [31:0] flag01 = {flag_q[1], flag_q[0]};
   wire [31:0] flag23 = {flag_q[3], flag_q[2]};
   wire [31:0] status = {22'h000000, unf_q, ovf_q, 3'h0, sp_q};
   wire [31:0] st_new = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
   wire        w_ctrl = wb_wr & (wb_adr_i == `SLMC_REG_CTRL);
   wire        w_st   = wb_wr & (wb_adr_i == `SLMC_REG_STATUS);
   wire        w_lm   = wb_wr & (wb_adr_i == `SLMC_REG_LOOP_MASK);
   wire        w_cm   = wb_wr & (wb_adr_i == `SLMC_REG_CONT_MASK);
   wire        w_f01  = wb_wr & (wb_adr_i == `SLMC_REG_FLAG01);
   wire        w_f23  = wb_wr & (wb_adr_i == `SLMC_REG_FLAG23);
   wire [31:0] m_lm   = merge({16'h0000, loop_q}, wb_dat_i, wb_sel_i);
   wire [31:0] m_cm   = merge({16'h0000, cont_q}, wb_dat_i, wb_sel_i);
   wire [31:0] m_f01  = merge(flag01, wb_dat_i, wb_sel_i);
   wire [31:0] m_f23  = merge(flag23, wb_dat_i, wb_sel_i);

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         ctrl_q   <= `SLMC_CTRL_RST;
      end else begin
         wb_ack_o <= wb_req;
         if (w_ctrl)
            ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_0003;
         else
            ctrl_q[`SLMC_CTRL_STK_CLR] <= 1'b0;
         if (wb_req & ~wb_we_i) begin
            case (wb_adr_i)
               `SLMC_REG_CTRL:      wb_dat_o <= ctrl_q;
               `SLMC_REG_STATUS:    wb_dat_o <= status;
               `SLMC_REG_LOOP_MASK: wb_dat_o <= {16'h0000, loop_q};
               `SLMC_REG_CONT_MASK: wb_dat_o <= {16'h0000, cont_q};
               `SLMC_REG_FLAG01:    wb_dat_o <= flag01;
               `SLMC_REG_FLAG23:    wb_dat_o <= flag23;
               default:             wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Mask, flag and stack update
   // ----------------------------------------
   // Instruction updates win over a register write in the same cycle,
   // so software should only poke masks while the stream is idle.
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         loop_q <= `SLMC_MASK_RST;
         cont_q <= `SLMC_MASK_RST;
         sp_q   <= 5'h00;
         ovf_q  <= 1'b0;
         unf_q  <= 1'b0;
         for (i = 0; i < 4; i = i + 1)
            flag_q[i] <= `SLMC_MASK_RST;
         for (i = 0; i < STACK_DEPTH; i = i + 1)
            stack_q[i] <= `SLMC_MASK_RST;
      end else begin
         // Sticky errors: a new event beats a write-one clear
         if (w_st & st_new[`SLMC_ST_OVF])
            ovf_q <= 1'b0;
         if (w_st & st_new[`SLMC_ST_UNF])
            unf_q <= 1'b0;
         if (push_req & stk_full)
            ovf_q <= 1'b1;
         if (tail_pop & stk_short)
            unf_q <= 1'b1;
         if (w_lm)
            loop_q <= m_lm[CHANNELS-1:0];
         if (w_cm)
            cont_q <= m_cm[CHANNELS-1:0];
         if (w_f01) begin
            flag_q[0] <= m_f01[15:0];
            flag_q[1] <= m_f01[31:16];
         end
         if (w_f23) begin
            flag_q[2] <= m_f23[15:0];
            flag_q[3] <= m_f23[31:16];
         end
         if (ctrl_q[`SLMC_CTRL_STK_CLR])
            sp_q <= 5'h00;
         else if (fire) begin
            case (instr_op_i)
               `SLMC_OP_SAVE_LOOP: begin
                  if (!stk_full) begin
                     stack_q[sp_q[3:0]] <= loop_q;
                     sp_q <= sp_q + 5'h01;
                  end
                  loop_q <= exec_mask_i;
               end
               `SLMC_OP_SAVE_CONT: begin
                  if (!stk_full) begin
                     stack_q[sp_q[3:0]] <= cont_q;
                     sp_q <= sp_q + 5'h01;
                  end
                  cont_q <= exec_mask_i;
               end
               `SLMC_OP_CONT_RELOAD: cont_q <= loop_q;
               `SLMC_OP_LOOP_TAIL: begin
                  if (|tail_res) begin
                     loop_q <= tail_res;
                  end else if (!stk_short) begin
                     cont_q <= stack_q[sp_m1[3:0]];
                     loop_q <= stack_q[sp_m2[3:0]];
                     sp_q   <= sp_m2;
                  end else begin
                     loop_q <= tail_res;
                  end
               end
               `SLMC_OP_BREAK: begin
                  loop_q <= brk_loop;
                  cont_q <= brk_cont;
               end
               `SLMC_OP_SKIP: cont_q <= brk_cont;
               `SLMC_OP_FLAG_AND:
                  flag_q[instr_flag_sel_i] <= flag_sel & flag_q[instr_flag_src_i];
               `SLMC_OP_FLAG_OR:
                  flag_q[instr_flag_sel_i] <= flag_sel | flag_q[instr_flag_src_i];
               `SLMC_OP_FLAG_XOR:
                  flag_q[instr_flag_sel_i] <= flag_sel ^ flag_q[instr_flag_src_i];
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Branch results
   // ----------------------------------------
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         done_o           <= 1'b0;
         branch_taken_o   <= 1'b0;
         branch_ip_o      <= 32'h0000_0000;
         cond_pop_count_o <= 16'h0000;
         pred_mask_o      <= `SLMC_MASK_RST;
      end else begin
         done_o           <= fire;
         branch_taken_o   <= 1'b0;
         cond_pop_count_o <= 16'h0000;
         if (fire) begin
            case (instr_op_i)
               `SLMC_OP_LOOP_TAIL: begin
                  branch_taken_o <= |tail_res;
                  branch_ip_o    <= rel_al;
               end
               `SLMC_OP_BREAK: begin
                  branch_taken_o <= ~(|brk_loop);
                  branch_ip_o    <= rel_al;
                  if (~(|brk_loop))
                     cond_pop_count_o <= instr_operand_i[31:16];
               end
               `SLMC_OP_SKIP: begin
                  branch_taken_o <= ~(|brk_cont);
                  branch_ip_o    <= rel_al;
               end
               `SLMC_OP_ALL4_BRANCH: begin
                  pred_mask_o    <= all4 & exec_mask_i;
                  branch_taken_o <= ~(|(all4 & exec_mask_i));
                  branch_ip_o    <= rel_al;
               end
               `SLMC_OP_JUMP_INDEX: begin
                  branch_taken_o <= 1'b1;
                  branch_ip_o    <= idx_al;
               end
               default: ;
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// File: slmc_loop_mask_ctrl_asserts.sv
// Checker for the loop mask control ports.
// Assumes binding to the design top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "slmc_map.vh"
module slmc_loop_mask_ctrl_asserts #(
   parameter CHANNELS = 16
) (
   // Inputs
   input wire logic                clk_i,
   input wire logic                rstn_i,
   input wire logic                wb_cyc_i,
   input wire logic                wb_stb_i,
   input wire logic                instr_valid_i,
   input wire logic [3:0]          instr_op_i,
   input wire logic [31:0]         instr_operand_i,
   input wire logic [31:0]         instr_ip_i,
   input wire logic [CHANNELS-1:0] exec_mask_i,
   input wire logic [CHANNELS-1:0] alive_mask_i,
   // Outputs
   input wire logic                wb_ack_o,
   input wire logic                instr_ready_o,
   input wire logic                done_o,
   input wire logic                branch_taken_o,
   input wire logic [31:0]         branch_ip_o,
   input wire logic [15:0]         cond_pop_count_o,
   input wire logic [CHANNELS-1:0] pred_mask_o,
   input wire logic [CHANNELS-1:0] loop_channel_mask_o,
   input wire logic [CHANNELS-1:0] skip_channel_mask_o
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   logic                take;
   logic [15:0]         nest;
   logic [31:0]         jmp_t;
   logic [CHANNELS-1:0] lim;
   assign take  = instr_valid_i && instr_ready_o;
   assign nest  = instr_operand_i[31:16];
   assign jmp_t = (instr_ip_i + instr_operand_i) & ~32'h7;
   assign lim   = loop_channel_mask_o & alive_mask_i & skip_channel_mask_o;
   sequence s_op(logic [3:0] code);
      take && instr_op_i == code;
   endsequence
   property p_wb_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_wb_ack: assert property (p_wb_ack) else $error("bus ack not one cycle");
   property p_idle;
      !take |=> !done_o && !branch_taken_o;
   endproperty
   a_idle: assert property (p_idle) else $error("done without instruction");
   property p_done;
      take |=> done_o;
   endproperty
   a_done: assert property (p_done) else $error("instruction not completed");
   property p_tail;
      s_op(`SLMC_OP_LOOP_TAIL) ##1 branch_taken_o |->
         loop_channel_mask_o != 0 && (loop_channel_mask_o & ~$past(lim)) == 0;
   endproperty
   a_tail: assert property (p_tail) else $error("tail mask wrong");
   property p_break;
      s_op(`SLMC_OP_BREAK) |=> (loop_channel_mask_o & $past(exec_mask_i)) == 0
         && branch_taken_o == (loop_channel_mask_o == 0);
   endproperty
   a_break: assert property (p_break) else $error("break mask wrong");
   property p_nest;
      s_op(`SLMC_OP_BREAK) |=> cond_pop_count_o == (branch_taken_o ? $past(nest) : 16'h0000);
   endproperty
   a_nest: assert property (p_nest) else $error("pop count wrong");
   property p_skip;
      s_op(`SLMC_OP_SKIP) |=> (skip_channel_mask_o & $past(exec_mask_i)) == 0
         && branch_taken_o == (skip_channel_mask_o == 0);
   endproperty
   a_skip: assert property (p_skip) else $error("skip mask wrong");
   property p_all4;
      s_op(`SLMC_OP_ALL4_BRANCH) |=> (pred_mask_o & ~$past(exec_mask_i)) == 0
         && branch_taken_o == (pred_mask_o == 0);
   endproperty
   a_all4: assert property (p_all4) else $error("predicate wrong");
   property p_jump;
      s_op(`SLMC_OP_JUMP_INDEX) |=> branch_taken_o && branch_ip_o == $past(jmp_t);
   endproperty
   a_jump: assert property (p_jump) else $error("indexed target wrong");
   property p_align;
      done_o && branch_taken_o |-> branch_ip_o[2:0] == 3'h0;
   endproperty
   a_align: assert property (p_align) else $error("target not aligned");
endmodule
bind slmc_loop_mask_ctrl slmc_loop_mask_ctrl_asserts #(.CHANNELS(CHANNELS))
   slmc_loop_mask_ctrl_asserts_i (.*);
`default_nettype wire

// File: slmc_loop_mask_ctrl_tb_top.sv
// Bench: random instruction stream checked against a queue mask model.
// Assumes the design, its map header and the checker compile alongside.
`timescale 1ns/1ps
`default_nettype none
`include "slmc_map.vh"
module slmc_loop_mask_ctrl_tb_top;
   // ----------------------------------------
   // Signals and model state
   // ----------------------------------------
   logic        clk_i, rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic        instr_valid_i, instr_ready_o, done_o, branch_taken_o;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i, instr_op_i, o;
   logic [1:0]  instr_flag_sel_i, instr_flag_src_i;
   logic [31:0] wb_dat_i, wb_dat_o, instr_operand_i, instr_ip_i, branch_ip_o, rd, d;
   logic [15:0] exec_mask_i, alive_mask_i, cond_pop_count_o, pred_mask_o, lm, cm;
   logic [15:0] loop_channel_mask_o, skip_channel_mask_o;
   logic [15:0] fl [4];
   logic [15:0] stk [$];
   integer      seed, miscompares, check_count;
   slmc_loop_mask_ctrl slmc_loop_mask_ctrl_i (.*);
   initial forever #20 clk_i = ~clk_i;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Bus master holds the request until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
      wb_adr_i <= a;
      wb_dat_i <= v;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   task automatic ins(input logic [3:0] op);
      logic [15:0] ex, al, t;
      logic [31:0] opd, pc, tip;
      logic [1:0]  fs, sr;
      logic        tk;
      {ex, al} = $random(seed);
      {opd, pc} = {$random(seed), $random(seed)};
      {fs, sr} = $random(seed);
      tip = (pc + {16'h0, opd[15:0]}) & ~32'h7;
      tk = 0;
      t = 0;
      @(posedge clk_i);
      {instr_valid_i, instr_op_i, instr_flag_sel_i, instr_flag_src_i} <= {1'b1, op, fs, sr};
      {instr_operand_i, instr_ip_i, exec_mask_i, alive_mask_i} <= {opd, pc, ex, al};
      case (op)
         `SLMC_OP_SAVE_LOOP: begin
            stk.push_back(lm);
            lm = ex;
         end
         `SLMC_OP_SAVE_CONT: begin
            stk.push_back(cm);
            cm = ex;
         end
         `SLMC_OP_CONT_RELOAD: cm = lm;
         `SLMC_OP_LOOP_TAIL: begin
            t = al & cm & fl[fs] & lm;
            tk = (t != 0);
            if (tk) lm = t;
            else begin
               cm = stk.pop_back();
               lm = stk.pop_back();
            end
         end
         `SLMC_OP_BREAK: begin
            lm = lm & ~ex;
            cm = cm & ~ex;
            tk = (lm == 0);
         end
         `SLMC_OP_SKIP: begin
            cm = cm & ~ex;
            tk = (cm == 0);
         end
         `SLMC_OP_FLAG_AND: fl[fs] = fl[fs] & fl[sr];
         `SLMC_OP_FLAG_OR: fl[fs] = fl[fs] | fl[sr];
         `SLMC_OP_FLAG_XOR: fl[fs] = fl[fs] ^ fl[sr];
         `SLMC_OP_ALL4_BRANCH: begin
            t = fl[0] & fl[1] & fl[2] & fl[3] & ex;
            tk = (t == 0);
         end
         `SLMC_OP_JUMP_INDEX: begin
            tk = 1;
            tip = (pc + opd) & ~32'h7;
         end
         default: ;
      endcase
      @(posedge clk_i);
      instr_valid_i <= 0;
      #1;
      chk(done_o, 1);
      chk(instr_ready_o, 1);
      chk(loop_channel_mask_o, lm);
      chk(skip_channel_mask_o, cm);
      chk(branch_taken_o, tk);
      if (tk) chk(branch_ip_o, tip);
      if (op == `SLMC_OP_BREAK) chk(cond_pop_count_o, tk ? opd[31:16] : 0);
      if (op == `SLMC_OP_ALL4_BRANCH) chk(pred_mask_o, t);
   endtask
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      seed = 32'ha1c0;
      {miscompares, check_count, lm, cm} = 0;
      {clk_i, rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, instr_valid_i} = 0;
      {wb_adr_i, wb_dat_i, instr_op_i, instr_flag_sel_i, instr_flag_src_i} = 0;
      {instr_operand_i, instr_ip_i, exec_mask_i, alive_mask_i} = 0;
      wb_sel_i = 4'hf;
      repeat (6) @(posedge clk_i);
      rstn_i <= 1;
      wb(0, `SLMC_REG_CTRL, 0);
      chk(rd, `SLMC_CTRL_RST);
      wb(0, 8'h40, 0);
      chk(rd, 0);
      d = $random(seed);
      wb(1, `SLMC_REG_LOOP_MASK, d);
      lm = d[15:0];
      wb(0, `SLMC_REG_LOOP_MASK, 0);
      chk(rd, {16'h0, lm});
      for (int i = 0; i < 2; i++) begin
         d = $random(seed);
         wb(1, i ? `SLMC_REG_FLAG23 : `SLMC_REG_FLAG01, d);
         {fl[2*i+1], fl[2*i]} = d;
      end
      // Structured loop as a program would write it
      ins(`SLMC_OP_SAVE_LOOP);
      ins(`SLMC_OP_SAVE_CONT);
      for (int p = 0; p < 6 && stk.size() == 2; p++) begin
         ins(`SLMC_OP_CONT_RELOAD);
         ins(`SLMC_OP_SKIP);
         ins(`SLMC_OP_FLAG_OR);
         ins(`SLMC_OP_LOOP_TAIL);
      end
      repeat (400) begin
         o = 4'(($random(seed) & 32'h7fff_ffff) % 11 + 1);
         if (o == `SLMC_OP_LOOP_TAIL && stk.size() < 2) o = `SLMC_OP_SAVE_LOOP;
         if (o <= `SLMC_OP_SAVE_CONT && stk.size() > 12) o = `SLMC_OP_LOOP_TAIL;
         ins(o);
      end
      wb(0, `SLMC_REG_FLAG01, 0);
      chk(rd, {fl[1], fl[0]});
      wb(0, `SLMC_REG_STATUS, 0);
      chk(rd, stk.size());
      wb(1, `SLMC_REG_CTRL, 3);
      stk.delete();
      wb(0, `SLMC_REG_STATUS, 0);
      chk(rd, 0);
      wb(0, `SLMC_REG_CTRL, 0);
      chk(rd, 1);
      wb(1, `SLMC_REG_CTRL, 0);
      instr_valid_i <= 1;
      @(posedge clk_i);
      #1;
      chk(instr_ready_o, 0);
      chk(done_o, 0);
      chk(loop_channel_mask_o, lm);
      summarize;
   end
   initial begin
      #400000;
      miscompares++;
      summarize;
   end
endmodule
`default_nettype wire
